// [bsrc_consts.vh]
`ifndef BSRC_CONSTS_VH
`define BSRC_CONSTS_VH

// ==========================================================================
// Register word indices (byte address = index * 4)
// ==========================================================================
`define BSRC_IDX_W            10
`define BSRC_IDX_SEND_START   10'h0c8
`define BSRC_IDX_TX_LEN       10'h0c9
`define BSRC_IDX_RX_LEN       10'h0ca
`define BSRC_IDX_RECV_START   10'h0cb
`define BSRC_IDX_ERR_COUNT    10'h0cc
`define BSRC_IDX_LIN_BASE     10'h0cd
`define BSRC_IDX_LOUT_BASE    10'h0ed
`define BSRC_IDX_BPIN_BASE    10'h10d
`define BSRC_IDX_CTRL         10'h150
`define BSRC_ARRAY_LEN        10'h020
`define BSRC_ADR_IDX_MSB      11
`define BSRC_ADR_IDX_LSB      2

// ==========================================================================
// Field layouts and reset values
// ==========================================================================
`define BSRC_STREAM_MSB       13
`define BSRC_STREAM_LSB       9
`define BSRC_CHAN_MSB         8
`define BSRC_CHAN_LSB         0
`define BSRC_START_MASK       16'h3fff
`define BSRC_LEN_MASK         16'h01ff
`define BSRC_CTRL_MASK        16'h0007
`define BSRC_CTRL_MODE32      0
`define BSRC_CTRL_TX_EN       1
`define BSRC_CTRL_RX_EN       2
`define BSRC_REG_RST          16'h0000
`define BSRC_RATE_RST         2'h0
`define BSRC_RATE_2M          2'h0
`define BSRC_RATE_16M         2'h3
`define BSRC_FAST_STREAMS     5'h10
`define BSRC_FAST_MSB         4

// ==========================================================================
// BER pattern and tally
// ==========================================================================
`define BSRC_PRBS_SEED        15'h7fff
`define BSRC_PRBS_OUT         14
`define BSRC_PRBS_TAP         13
`define BSRC_TALLY_RST        16'h0000
`define BSRC_TALLY_MAX        16'hffff
`define BSRC_TALLY_ONE        16'h0001

// ==========================================================================
// Bus handshake states, one-hot
// ==========================================================================
`define BSRC_ST_IDLE          3'h1
`define BSRC_ST_WAIT          3'h2
`define BSRC_ST_ACK           3'h4

`endif

// [bsrc_rate_mem.v]
`timescale 1ns/10ps
`default_nettype none
`include "bsrc_consts.vh"

module bsrc_rate_mem #(
    parameter DW    = 2,
    parameter AW    = 5,
    parameter DEPTH = 32
) (
    input  wire          clk_i,     // System clock
    input  wire          rst_i,     // Synchronous reset
    input  wire          we_i,      // Write strobe
    input  wire [AW-1:0] waddr_i,   // Write index
    input  wire [DW-1:0] wdata_i,   // Write data
    input  wire [AW-1:0] raddr_a_i, // Bus read index
    output reg  [DW-1:0] rdata_a_o, // Bus read data
    input  wire [AW-1:0] raddr_b_i, // Datapath lookup index
    output reg  [DW-1:0] rdata_b_o  // Datapath lookup data
);

    reg [DW-1:0] mem [0:DEPTH-1];
    integer      i;

    // Flop array so every selector resets to the lowest rate
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            for (i = 0; i < DEPTH; i = i + 1)
                mem[i] <= `BSRC_RATE_RST;
            rdata_a_o <= `BSRC_RATE_RST;
            rdata_b_o <= `BSRC_RATE_RST;
        end
        else
        begin
            if (we_i)
                mem[waddr_i] <= wdata_i;
            rdata_a_o <= mem[raddr_a_i];
            rdata_b_o <= mem[raddr_b_i];
        end
    end

endmodule // bsrc_rate_mem

`default_nettype wire

// [bsrc_ber_engine.v]
`timescale 1ns/10ps
`default_nettype none
`include "bsrc_consts.vh"

module bsrc_ber_engine (
    input  wire        clk_i,                  // System clock
    input  wire        rst_i,                  // Synchronous reset
    input  wire        tx_enable_i,            // Generator enable
    input  wire        rx_enable_i,            // Checker enable
    input  wire [4:0]  ber_send_stream_sel,    // Send stream
    input  wire [8:0]  ber_send_start_channel, // Send start channel
    input  wire [8:0]  ber_tx_extra_channels,  // Extra send channels
    input  wire [4:0]  ber_receive_stream_sel, // Receive stream
    input  wire [8:0]  ber_receive_start_channel, // Receive start channel
    input  wire [8:0]  ber_rx_extra_channels,  // Extra receive channels
    input  wire        tx_slot_i,              // Output bit slot strobe
    input  wire [4:0]  tx_stream_i,            // Output slot stream
    input  wire [8:0]  tx_chan_i,              // Output slot channel
    input  wire        rx_valid_i,             // Input bit strobe
    input  wire [4:0]  rx_stream_i,            // Input bit stream
    input  wire [8:0]  rx_chan_i,              // Input bit channel
    input  wire        rx_bit_i,               // Input bit value
    output reg         tx_en_o,                // Drive BER bit this slot
    output reg         tx_bit_o,               // BER bit
    output reg  [15:0] error_tally_o           // Accumulated bit errors
);

    reg  [14:0] tx_lfsr;
    reg  [14:0] rx_lfsr;
    wire        tx_hit;
    wire        rx_hit;

    function [14:0] prbs_next;
        input [14:0] s;
        begin
            prbs_next = {s[13:0], s[`BSRC_PRBS_OUT] ^ s[`BSRC_PRBS_TAP]};
        end
    endfunction

    // Window runs from start through start + extra; widened to avoid wrap
    function in_window;
        input [4:0] str;
        input [8:0] chan;
        input [4:0] sel;
        input [8:0] start;
        input [8:0] extra;
        reg   [9:0] last;
        begin
            last      = {1'b0, start} + {1'b0, extra};
            in_window = (str == sel) && (chan >= start) && ({1'b0, chan} <= last);
        end
    endfunction

    assign tx_hit = tx_slot_i && tx_enable_i &&
                    in_window(tx_stream_i, tx_chan_i, ber_send_stream_sel,
                              ber_send_start_channel, ber_tx_extra_channels);  // RULE1 RULE2 RULE3
    assign rx_hit = rx_valid_i && rx_enable_i &&
                    in_window(rx_stream_i, rx_chan_i, ber_receive_stream_sel,
                              ber_receive_start_channel, ber_rx_extra_channels); // RULE4 RULE5 RULE6

    // ======================================================================
    // Generator
    // ======================================================================
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            tx_lfsr  <= `BSRC_PRBS_SEED;
            tx_en_o  <= 1'b0;
            tx_bit_o <= 1'b0;
        end
        else
        begin
            tx_en_o <= tx_hit;
            if (!tx_enable_i)
                tx_lfsr <= `BSRC_PRBS_SEED;
            else if (tx_hit)
            begin
                tx_bit_o <= tx_lfsr[`BSRC_PRBS_OUT];
                tx_lfsr  <= prbs_next(tx_lfsr);
            end
        end
    end

    // ======================================================================
    // Checker: not self-synchronising, so both ends must start from seed
    // ======================================================================
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rx_lfsr       <= `BSRC_PRBS_SEED;
            error_tally_o <= `BSRC_TALLY_RST;  // RULE7
        end
        else if (!rx_enable_i)
            rx_lfsr <= `BSRC_PRBS_SEED;
        else if (rx_hit)
        begin
            rx_lfsr <= prbs_next(rx_lfsr);
            // Saturates rather than wrapping so a high error rate is not hidden
            if ((rx_bit_i != rx_lfsr[`BSRC_PRBS_OUT]) && (error_tally_o != `BSRC_TALLY_MAX))
                error_tally_o <= error_tally_o + `BSRC_TALLY_ONE;  // RULE12
        end
    end

endmodule // bsrc_ber_engine

`default_nettype wire

// [bsrc_top.v]
// Overview of operation
// RULE1: Bits 13..9 of the send-start register pick the backplane output stream carrying the BER pattern.
// RULE2: Bits 8..0 of the send-start register give the first output channel carrying the BER pattern.
// RULE3: Each frame the pattern goes out on the start channel and the number of extra channels in the tx length.
// RULE4: Each frame received bits are compared on the receive start channel plus the rx length extra channels.
// RULE5: Bits 13..9 of the receive-start register pick the backplane input stream that is checked.
// RULE6: Bits 8..0 of the receive-start register give the first input channel that is checked.
// RULE7: The 16-bit error count is read-only, ignores writes and resets to zero.
// RULE8: Each of 32 local input streams has a two-bit rate code, 00/01/10/11 for 2/4/8/16 Mb/s.
// RULE9: Each of 32 local output streams has a two-bit rate code, 00/01/10/11 for 2/4/8/16 Mb/s.
// RULE10: Each of 32 backplane input streams has a two-bit rate code, 00/01/10/11 for 2/4/8/16 Mb/s.
// RULE11: In 32 Mb/s mode backplane input codes are ignored, streams 0-15 run fast and 16-31 are unused.
// RULE12: The error count rises once per received in-window bit that differs from the expected pattern.
`timescale 1ns/10ps
`default_nettype none
`include "bsrc_consts.vh"

module bsrc_top (
    input  wire        clk_i,                // 200 MHz system clock
    input  wire        rst_i,                // Synchronous reset, high
    input  wire [11:0] adr_i,                // Wishbone byte address
    input  wire [31:0] dat_i,                // Wishbone write data
    output reg  [31:0] dat_o,                // Wishbone read data
    input  wire        we_i,                 // Wishbone write enable
    input  wire [3:0]  sel_i,                // Wishbone byte selects
    input  wire        cyc_i,                // Wishbone cycle
    input  wire        stb_i,                // Wishbone strobe
    output reg         ack_o,                // Wishbone acknowledge
    input  wire [4:0]  local_in_stream_i,    // Local input rate lookup
    output reg  [1:0]  local_in_rate_sel_o,  // Local input rate code
    input  wire [4:0]  local_out_stream_i,   // Local output rate lookup
    output reg  [1:0]  local_out_rate_sel_o, // Local output rate code
    input  wire [4:0]  bp_in_stream_i,       // Backplane input rate lookup
    output reg  [1:0]  bp_in_rate_sel_o,     // Backplane input rate code
    output reg         bp_in_fast_o,         // Looked-up stream runs at 32 Mb/s
    output reg         bp_in_unused_o,       // Looked-up stream is unused
    output reg         bp_mode_32m_o,        // Global 32 Mb/s mode
    input  wire        bp_tx_slot_i,         // Backplane output bit slot
    input  wire [4:0]  bp_tx_stream_i,       // Slot stream
    input  wire [8:0]  bp_tx_chan_i,         // Slot channel
    output wire        ber_tx_en_o,          // Insert BER bit
    output wire        ber_tx_bit_o,         // BER bit value
    input  wire        bp_rx_valid_i,        // Backplane input bit strobe
    input  wire [4:0]  bp_rx_stream_i,       // Input bit stream
    input  wire [8:0]  bp_rx_chan_i,         // Input bit channel
    input  wire        bp_rx_bit_i           // Input bit value
);

    // ======================================================================
    // Registers and bus state
    // ======================================================================
    reg  [15:0]             bp_ber_send_start;
    reg  [15:0]             bp_ber_tx_length;
    reg  [15:0]             bp_ber_rx_length;
    reg  [15:0]             bp_ber_receive_start;
    reg  [15:0]             ctrl;
    reg  [2:0]              state;
    reg  [2:0]              next_state;
    reg  [4:0]              bp_in_stream_q;
    reg  [31:0]             next_dat;
    wire [`BSRC_IDX_W-1:0]  idx;
    wire [`BSRC_IDX_W-1:0]  lin_off;
    wire [`BSRC_IDX_W-1:0]  lout_off;
    wire [`BSRC_IDX_W-1:0]  bpin_off;
    wire                    hit_lin;
    wire                    hit_lout;
    wire                    hit_bpin;
    wire                    commit;
    wire                    do_write;
    wire [1:0]              lin_bus;
    wire [1:0]              lout_bus;
    wire [1:0]              bpin_bus;
    wire [1:0]              lin_look;
    wire [1:0]              lout_look;
    wire [1:0]              bpin_look;
    wire [15:0]             error_tally;

    assign idx      = adr_i[`BSRC_ADR_IDX_MSB:`BSRC_ADR_IDX_LSB];
    assign lin_off  = idx - `BSRC_IDX_LIN_BASE;
    assign lout_off = idx - `BSRC_IDX_LOUT_BASE;
    assign bpin_off = idx - `BSRC_IDX_BPIN_BASE;
    assign hit_lin  = (idx >= `BSRC_IDX_LIN_BASE) && (lin_off < `BSRC_ARRAY_LEN);
    assign hit_lout = (idx >= `BSRC_IDX_LOUT_BASE) && (lout_off < `BSRC_ARRAY_LEN);
    assign hit_bpin = (idx >= `BSRC_IDX_BPIN_BASE) && (bpin_off < `BSRC_ARRAY_LEN);

    // Writes land on the edge that raises ack
    assign commit   = (state == `BSRC_ST_WAIT) && cyc_i && stb_i;
    assign do_write = commit && we_i;

    // Byte-lane merge; bits outside the mask stay zero
    function [15:0] merge16;
        input [15:0] old;
        input [15:0] wr;
        input [1:0]  sel;
        input [15:0] mask;
        reg   [15:0] lanes;
        begin
            lanes   = {{8{sel[1]}}, {8{sel[0]}}};
            merge16 = ((old & ~lanes) | (wr & lanes)) & mask;
        end
    endfunction

    // ======================================================================
    // Wishbone handshake: request, wait for array read, ack one cycle
    // ======================================================================
    always @*
    begin
        next_state = state;
        case (state)
            `BSRC_ST_IDLE:
                if (cyc_i && stb_i)
                    next_state = `BSRC_ST_WAIT;
            `BSRC_ST_WAIT:
                next_state = (cyc_i && stb_i) ? `BSRC_ST_ACK : `BSRC_ST_IDLE;
            `BSRC_ST_ACK:
                next_state = `BSRC_ST_IDLE;
            default:
                next_state = `BSRC_ST_IDLE;
        endcase
    end

    // Read mux; unmapped and reserved bits read as zero
    always @*
    begin
        next_dat = 32'h00000000;
        case (idx)
            `BSRC_IDX_SEND_START: next_dat[15:0] = bp_ber_send_start;
            `BSRC_IDX_TX_LEN:     next_dat[15:0] = bp_ber_tx_length;
            `BSRC_IDX_RX_LEN:     next_dat[15:0] = bp_ber_rx_length;
            `BSRC_IDX_RECV_START: next_dat[15:0] = bp_ber_receive_start;
            `BSRC_IDX_ERR_COUNT:  next_dat[15:0] = error_tally;  // RULE7
            `BSRC_IDX_CTRL:       next_dat[15:0] = ctrl;
            default:
            begin
                if (hit_lin)
                    next_dat[1:0] = lin_bus;
                else if (hit_lout)
                    next_dat[1:0] = lout_bus;
                else if (hit_bpin)
                    next_dat[1:0] = bpin_bus;
            end
        endcase
    end

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state <= `BSRC_ST_IDLE;
            ack_o <= 1'b0;
            dat_o <= 32'h00000000;
        end
        else
        begin
            state <= next_state;
            ack_o <= commit;
            if (commit && !we_i)
                dat_o <= next_dat;
        end
    end

    // ======================================================================
    // Scalar configuration registers
    // ======================================================================
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            bp_ber_send_start    <= `BSRC_REG_RST;
            bp_ber_tx_length     <= `BSRC_REG_RST;
            bp_ber_rx_length     <= `BSRC_REG_RST;
            bp_ber_receive_start <= `BSRC_REG_RST;
            ctrl                 <= `BSRC_REG_RST;
        end
        else if (do_write)
        begin
            case (idx)
                `BSRC_IDX_SEND_START:
                    bp_ber_send_start <= merge16(bp_ber_send_start, dat_i[15:0], sel_i[1:0],
                                                 `BSRC_START_MASK);  // RULE1 RULE2
                `BSRC_IDX_TX_LEN:
                    bp_ber_tx_length <= merge16(bp_ber_tx_length, dat_i[15:0], sel_i[1:0],
                                                `BSRC_LEN_MASK);  // RULE3
                `BSRC_IDX_RX_LEN:
                    bp_ber_rx_length <= merge16(bp_ber_rx_length, dat_i[15:0], sel_i[1:0],
                                                `BSRC_LEN_MASK);  // RULE4
                `BSRC_IDX_RECV_START:
                    bp_ber_receive_start <= merge16(bp_ber_receive_start, dat_i[15:0], sel_i[1:0],
                                                    `BSRC_START_MASK);  // RULE5 RULE6
                `BSRC_IDX_CTRL:
                    ctrl <= merge16(ctrl, dat_i[15:0], sel_i[1:0], `BSRC_CTRL_MASK);
                default:
                    ctrl <= ctrl;
            endcase
        end
    end

    // ======================================================================
    // Per-stream rate arrays
    // ======================================================================
    bsrc_rate_mem #(.DW(2), .AW(5), .DEPTH(32)) u_lin_rates (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .we_i      (do_write && hit_lin && sel_i[0]),  // RULE8
        .waddr_i   (lin_off[4:0]),
        .wdata_i   (dat_i[1:0]),
        .raddr_a_i (lin_off[4:0]),
        .rdata_a_o (lin_bus),
        .raddr_b_i (local_in_stream_i),
        .rdata_b_o (lin_look)
    );

    bsrc_rate_mem #(.DW(2), .AW(5), .DEPTH(32)) u_lout_rates (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .we_i      (do_write && hit_lout && sel_i[0]),  // RULE9
        .waddr_i   (lout_off[4:0]),
        .wdata_i   (dat_i[1:0]),
        .raddr_a_i (lout_off[4:0]),
        .rdata_a_o (lout_bus),
        .raddr_b_i (local_out_stream_i),
        .rdata_b_o (lout_look)
    );

    bsrc_rate_mem #(.DW(2), .AW(5), .DEPTH(32)) u_bpin_rates (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .we_i      (do_write && hit_bpin && sel_i[0]),  // RULE10
        .waddr_i   (bpin_off[4:0]),
        .wdata_i   (dat_i[1:0]),
        .raddr_a_i (bpin_off[4:0]),
        .rdata_a_o (bpin_bus),
        .raddr_b_i (bp_in_stream_i),
        .rdata_b_o (bpin_look)
    );

    // Extra stage keeps the 32 Mb/s flags at the same two-cycle latency as the lookups
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            bp_in_stream_q       <= 5'h00;
            local_in_rate_sel_o  <= `BSRC_RATE_RST;
            local_out_rate_sel_o <= `BSRC_RATE_RST;
            bp_in_rate_sel_o     <= `BSRC_RATE_RST;
            bp_in_fast_o         <= 1'b0;
            bp_in_unused_o       <= 1'b0;
            bp_mode_32m_o        <= 1'b0;
        end
        else
        begin
            bp_in_stream_q       <= bp_in_stream_i;
            local_in_rate_sel_o  <= lin_look;   // RULE8
            local_out_rate_sel_o <= lout_look;  // RULE9
            bp_mode_32m_o        <= ctrl[`BSRC_CTRL_MODE32];
            if (ctrl[`BSRC_CTRL_MODE32])
            begin
                // Stored codes stay readable but do not reach the port
                bp_in_rate_sel_o <= `BSRC_RATE_16M;  // RULE11
                bp_in_fast_o     <= !bp_in_stream_q[`BSRC_FAST_MSB];  // RULE11
                bp_in_unused_o   <= bp_in_stream_q[`BSRC_FAST_MSB];   // RULE11
            end
            else
            begin
                bp_in_rate_sel_o <= bpin_look;  // RULE10
                bp_in_fast_o     <= 1'b0;
                bp_in_unused_o   <= 1'b0;
            end
        end
    end

    // ======================================================================
    // BER generator and checker
    // ======================================================================
    bsrc_ber_engine u_ber (
        .clk_i                     (clk_i),
        .rst_i                     (rst_i),
        .tx_enable_i               (ctrl[`BSRC_CTRL_TX_EN]),
        .rx_enable_i               (ctrl[`BSRC_CTRL_RX_EN]),
        .ber_send_stream_sel       (bp_ber_send_start[`BSRC_STREAM_MSB:`BSRC_STREAM_LSB]),
        .ber_send_start_channel    (bp_ber_send_start[`BSRC_CHAN_MSB:`BSRC_CHAN_LSB]),
        .ber_tx_extra_channels     (bp_ber_tx_length[`BSRC_CHAN_MSB:`BSRC_CHAN_LSB]),
        .ber_receive_stream_sel    (bp_ber_receive_start[`BSRC_STREAM_MSB:`BSRC_STREAM_LSB]),
        .ber_receive_start_channel (bp_ber_receive_start[`BSRC_CHAN_MSB:`BSRC_CHAN_LSB]),
        .ber_rx_extra_channels     (bp_ber_rx_length[`BSRC_CHAN_MSB:`BSRC_CHAN_LSB]),
        .tx_slot_i                 (bp_tx_slot_i),
        .tx_stream_i               (bp_tx_stream_i),
        .tx_chan_i                 (bp_tx_chan_i),
        .rx_valid_i                (bp_rx_valid_i),
        .rx_stream_i               (bp_rx_stream_i),
        .rx_chan_i                 (bp_rx_chan_i),
        .rx_bit_i                  (bp_rx_bit_i),
        .tx_en_o                   (ber_tx_en_o),
        .tx_bit_o                  (ber_tx_bit_o),
        .error_tally_o             (error_tally)
    );

endmodule // bsrc_top

`default_nettype wire

// [bsrc_properties.sv]
`timescale 1ns/10ps
`default_nettype none
module bsrc_checker (
    input wire logic        clk_i,            // Clock
    input wire logic        rst_i,            // Reset
    input wire logic        cyc_i,            // Cycle
    input wire logic        stb_i,            // Strobe
    input wire logic        we_i,             // Write
    input wire logic [31:0] dat_o,            // Read data
    input wire logic        ack_o,            // Ack
    input wire logic [4:0]  bp_in_stream_i,   // Lookup index
    input wire logic [1:0]  bp_in_rate_sel_o, // Rate code
    input wire logic        bp_in_fast_o,     // Fast
    input wire logic        bp_in_unused_o,   // Unused
    input wire logic        bp_mode_32m_o,    // Mode
    input wire logic        bp_tx_slot_i,     // Slot
    input wire logic        ber_tx_en_o,      // BER enable
    input wire logic        ber_tx_bit_o      // BER bit
);
// ==========================================
// Bus and datapath properties
default clocking cb @(posedge clk_i); endclocking
default disable iff (rst_i);
sequence s_req2; cyc_i && stb_i ##1 cyc_i && stb_i; endsequence
// Four samples so a mode edge never races the lookup pipe
sequence s_mode4; bp_mode_32m_o [*4]; endsequence
sequence s_plain4; !bp_mode_32m_o [*4]; endsequence
a_ack_single: assert property (s_req2 ##1 ack_o |=> !ack_o) else $error("ack longer than one cycle");
a_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i) && $past(cyc_i && stb_i, 2))
    else $error("ack without request");
a_dat_cause: assert property ($changed(dat_o) |-> ack_o && !$past(we_i)) else $error("read data moved");
a_dat_high: assert property (dat_o[31:16] == 16'h0) else $error("upper read data set");
a_mode_code: assert property (s_mode4 |-> bp_in_rate_sel_o == 2'h3 &&
    bp_in_fast_o == ($past(bp_in_stream_i, 2) < 5'h10)) else $error("fast mode code wrong");
a_mode_unused: assert property (s_mode4 |-> bp_in_unused_o == ($past(bp_in_stream_i, 2) >= 5'h10))
    else $error("unused flag wrong");
a_plain_mode: assert property (s_plain4 |-> !bp_in_fast_o && !bp_in_unused_o) else $error("flags set");
a_tx_cause: assert property (ber_tx_en_o |-> $past(bp_tx_slot_i)) else $error("BER bit without slot");
a_tx_hold: assert property (!ber_tx_en_o |-> $stable(ber_tx_bit_o)) else $error("BER bit moved");
endmodule // bsrc_checker
bind bsrc_top bsrc_checker chk (.*);
`default_nettype wire

// [ber_and_stream_rate_config_tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
`include "bsrc_consts.vh"
module ber_and_stream_rate_config_tb_top;
logic        clk_i, rst_i, we_i, cyc_i, stb_i, ack_o, bp_tx_slot_i, bp_rx_valid_i, bp_rx_bit_i;
logic        bp_in_fast_o, bp_in_unused_o, bp_mode_32m_o, ber_tx_en_o, ber_tx_bit_o;
logic [11:0] adr_i;
logic [31:0] dat_i, dat_o;
logic [3:0]  sel_i;
logic [4:0]  local_in_stream_i, local_out_stream_i, bp_in_stream_i, bp_tx_stream_i, bp_rx_stream_i;
logic [1:0]  local_in_rate_sel_o, local_out_rate_sel_o, bp_in_rate_sel_o;
logic [8:0]  bp_tx_chan_i, bp_rx_chan_i;
logic [14:0] prbs;
logic [15:0] q;
int          num_errors, checks;
bsrc_top uut (.*);
initial
begin
    clk_i = 0;
    forever #2.5 clk_i = ~clk_i;
end
// ==========================================
// Shared tasks
task test_done;
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
endtask
task chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
        num_errors++;
        $display("wrong value t=%0t got %h exp %h", $time, got, exp);
    end
endtask
task wb(input logic w, input logic [9:0] idx, input logic [15:0] d);
    int n;
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, dat_i} <= {1'b1, 1'b1, w, idx, 2'h0, 16'h0, d};
    n = 0;
    do begin @(posedge clk_i); n++; end while (ack_o !== 1'b1 && n < 50);
    if (n >= 50) begin num_errors++; test_done; end
    q = dat_o[15:0];
    {cyc_i, stb_i, we_i} <= 3'h0;
endtask
task rd(input logic [9:0] idx, input logic [15:0] exp);
    wb(1'b0, idx, 16'h0);
    chk(q, exp);
endtask
// Expected pattern, one bit per slot
function logic nb();
    nb = prbs[14];
    prbs = {prbs[13:0], prbs[14] ^ prbs[13]};
endfunction
task pulse(input logic tx, input logic [4:0] s, input logic [8:0] c, input logic b);
    @(posedge clk_i);
    {bp_tx_slot_i, bp_rx_valid_i} <= {tx, !tx};
    {bp_tx_stream_i, bp_tx_chan_i, bp_rx_stream_i, bp_rx_chan_i, bp_rx_bit_i} <= {s, c, s, c, b};
    @(posedge clk_i);
    {bp_tx_slot_i, bp_rx_valid_i} <= 2'h0;
    #1;
endtask
// ==========================================
// Scenarios
task s_regs;
    for (int i = 'h0c8; i <= 'h0cc; i++) rd(i, 16'h0);
    for (int i = 'h0c8; i <= 'h0cc; i++) wb(1'b1, i, 16'hffff);
    rd(`BSRC_IDX_SEND_START, 16'h3fff);
    rd(`BSRC_IDX_TX_LEN, 16'h01ff);
    rd(`BSRC_IDX_RX_LEN, 16'h01ff);
    rd(`BSRC_IDX_RECV_START, 16'h3fff);
    rd(`BSRC_IDX_ERR_COUNT, 16'h0);
    rd(10'h3ff, 16'h0);
endtask
task s_rates;
    for (int i = 0; i < 32; i++)
    begin
        wb(1'b1, `BSRC_IDX_LIN_BASE + i, i % 4);
        wb(1'b1, `BSRC_IDX_LOUT_BASE + i, (i + 1) % 4);
        wb(1'b1, `BSRC_IDX_BPIN_BASE + i, (i + 2) % 4);
    end
    rd(`BSRC_IDX_LIN_BASE + 5, 16'h1);
    for (int i = 0; i < 32; i++)
    begin
        @(posedge clk_i);
        {local_in_stream_i, local_out_stream_i, bp_in_stream_i} <= {3{5'(i)}};
        repeat (3) @(posedge clk_i);
        #1;
        chk(local_in_rate_sel_o, i % 4);
        chk(local_out_rate_sel_o, (i + 1) % 4);
        chk(bp_in_rate_sel_o, (i + 2) % 4);
    end
endtask
task s_mode;
    wb(1'b1, `BSRC_IDX_CTRL, 16'h1);
    for (int i = 3; i < 32; i += 17)
    begin
        @(posedge clk_i);
        bp_in_stream_i <= 5'(i);
        repeat (4) @(posedge clk_i);
        #1;
        chk(bp_in_rate_sel_o, 16'h3);
        chk(bp_mode_32m_o, 16'h1);
        chk(bp_in_fast_o, i < 16);
        chk(bp_in_unused_o, i >= 16);
    end
    rd(`BSRC_IDX_BPIN_BASE + 3, 16'h1);
endtask
task s_ber;
    wb(1'b1, `BSRC_IDX_SEND_START, 16'h0a0a);
    wb(1'b1, `BSRC_IDX_TX_LEN, 16'h2);
    wb(1'b1, `BSRC_IDX_RECV_START, 16'h0e02);
    wb(1'b1, `BSRC_IDX_RX_LEN, 16'h1);
    wb(1'b1, `BSRC_IDX_CTRL, 16'h6);
    prbs = `BSRC_PRBS_SEED;
    for (int c = 8; c < 14; c++)
    begin
        pulse(1'b1, 5'h5, c, 1'b0);
        chk(ber_tx_en_o, c >= 10 && c <= 12);
        if (c >= 10 && c <= 12) chk(ber_tx_bit_o, nb());
    end
    pulse(1'b1, 5'h4, 9'h00b, 1'b0);
    chk(ber_tx_en_o, 16'h0);
    prbs = `BSRC_PRBS_SEED;
    // Wrong bits outside the window must not count
    pulse(1'b0, 5'h7, 9'h001, 1'b0);
    pulse(1'b0, 5'h7, 9'h002, nb());
    pulse(1'b0, 5'h7, 9'h003, !nb());
    pulse(1'b0, 5'h7, 9'h004, !nb());
    pulse(1'b0, 5'h6, 9'h002, 1'b0);
    rd(`BSRC_IDX_ERR_COUNT, 16'h1);
endtask
initial
begin
    {cyc_i, stb_i, we_i, bp_tx_slot_i, bp_rx_valid_i, bp_rx_bit_i, adr_i, dat_i} = '0;
    {local_in_stream_i, local_out_stream_i, bp_in_stream_i, bp_tx_stream_i, bp_rx_stream_i} = '0;
    {bp_tx_chan_i, bp_rx_chan_i} = '0;
    sel_i = 4'hf;
    rst_i = 1'b1;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    s_regs;
    s_rates;
    s_mode;
    s_ber;
    test_done;
end
endmodule // ber_and_stream_rate_config_tb_top
`default_nettype wire
